// ---- src/link_slot_pkg.sv ----
// Package with offsets, field positions and reset values of the link and slot registers.
// Functional notes
// - Two-bit power-state entry control, read-write, resets to 00.
// - Read completion boundary bit reads as zero always.
// - Link disable and retrain writable only in reverse bridge; both reset zero.
// - Negotiated speed field bits 19:16 read-only, resets to 1.
// - Hot-plug slot capability bits read 1 only when hot-plug enabled in reverse.
// - Hot-plug capability bits loaded from the strapping input after reset.
package link_slot_pkg;
  localparam logic [7:0] OFF_LINK = 8'hC0;
  localparam logic [7:0] OFF_SLOT_CAP = 8'hC4;
  localparam logic [7:0] OFF_SLOT_CTL = 8'hC8;
  localparam logic [7:0] OFF_STRAP = 8'hCC;
  localparam int ASPM_LSB = 0;
  localparam int RCB_BIT = 3;
  localparam int LDIS_BIT = 4;
  localparam int RETR_BIT = 5;
  localparam int CCLK_BIT = 6;
  localparam int XSYNC_BIT = 7;
  localparam int SPEED_LSB = 16;
  localparam int WIDTH_LSB = 20;
  localparam int TERR_BIT = 26;
  localparam int TRAIN_BIT = 27;
  localparam int SCLK_BIT = 28;
  localparam logic [1:0] ASPM_RST = 2'h0;
  localparam logic [3:0] SPEED_RST = 4'h1;
  localparam logic [5:0] WIDTH_RST = 6'h04;
  localparam logic [10:0] SLOT_CTL_RST = 11'h000;
  localparam logic [6:0] HP_CAP_MASK = 7'h5D;
endpackage

// ---- src/strap_sync.sv ----
// Three-stage synchroniser that reports a pin level once the last two stages agree.
`timescale 1ns/10ps
module strap_sync (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_i,
  // Pin and filtered level.
  input wire logic pin_i,
  output logic level_o
);
  logic s1_q;
  logic s2_q;
  logic s3_q;

  // Shift the pin through three flops and update the level when stages two and three agree.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
      level_o <= 1'b0;
    end else begin
      s1_q <= pin_i;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (s2_q == s3_q) begin
        level_o <= s3_q;
      end
    end
  end
endmodule // strap_sync

// ---- src/link_slot_config_regs.sv ----
// Link control, link status, slot capability and slot control registers on a Wishbone slave.
//
// The implementer's own choice: the Wishbone interface to the registers.
`timescale 1ns/10ps
module link_slot_config_regs (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone classic slave.
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // Straps and link state from surrounding logic.
  input wire logic reverse_i,
  input wire logic hotplug_strap_i,
  input wire logic [5:0] neg_width_i,
  input wire logic train_err_i,
  input wire logic training_i,
  // Control outputs.
  output logic [1:0] aspm_ctl_o,
  output logic link_disable_o,
  output logic retrain_o,
  output logic [10:0] slot_ctl_o
);
  import link_slot_pkg::*;

  logic rev_lvl;
  logic hp_lvl;
  logic rev_q;
  logic hp_q;
  logic strap_cnt_q;
  logic [1:0] aspm_q;
  logic ldis_q;
  logic retr_q;
  logic cclk_q;
  logic xsync_q;
  logic [10:0] slot_ctl_q;
  logic [5:0] width_q;
  logic terr_q;
  logic train_q;
  logic [31:0] rd_d;
  logic wr_go;
  logic [6:0] hp_bits;

  // Both straps come from pins and pass the synchroniser.
  strap_sync u_rev (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .pin_i(reverse_i),
    .level_o(rev_lvl)
  );
  strap_sync u_hp (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .pin_i(hotplug_strap_i),
    .level_o(hp_lvl)
  );

  // Register the synchronised straps on every cycle out of reset; strap_cnt_q sets on the first one.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rev_q <= 1'b0;
      hp_q <= 1'b0;
      strap_cnt_q <= 1'b0;
    end else begin
      rev_q <= rev_lvl;
      hp_q <= hp_lvl;
      strap_cnt_q <= 1'b1;
    end
  end

  // Single-cycle acknowledge; writes take effect on the acknowledging edge.
  assign wr_go = cyc_i && stb_i && we_i && !ack_o;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
    end else begin
      ack_o <= cyc_i && stb_i && !ack_o;
    end
  end

  // Link control fields; writes to read-only bits are dropped.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      aspm_q <= ASPM_RST;
      ldis_q <= 1'b0;
      retr_q <= 1'b0;
      cclk_q <= 1'b0;
      xsync_q <= 1'b0;
    end else if (wr_go && adr_i == OFF_LINK && sel_i[0]) begin
      aspm_q <= dat_i[ASPM_LSB+:2];
      cclk_q <= dat_i[CCLK_BIT];
      xsync_q <= dat_i[XSYNC_BIT];
      if (rev_q) begin
        ldis_q <= dat_i[LDIS_BIT];
        retr_q <= dat_i[RETR_BIT];
      end
    end
  end

  // Slot control enables, byte lanes 0 and 1.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      slot_ctl_q <= SLOT_CTL_RST;
    end else if (wr_go && adr_i == OFF_SLOT_CTL) begin
      if (sel_i[0]) begin
        slot_ctl_q[7:0] <= dat_i[7:0];
      end
      if (sel_i[1]) begin
        slot_ctl_q[10:8] <= dat_i[10:8];
      end
    end
  end

  // Capture link state reported by the training logic.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      width_q <= WIDTH_RST;
      terr_q <= 1'b0;
      train_q <= 1'b0;
    end else begin
      width_q <= neg_width_i;
      terr_q <= train_err_i;
      train_q <= training_i;
    end
  end

  // Hot-plug capability bits follow the straps.
  assign hp_bits = (hp_q && rev_q) ? HP_CAP_MASK : 7'h00;

  // Read multiplexer; reserved bits and unmapped words return zero.
  always_comb begin
    rd_d = 32'h0000_0000;
    case (adr_i)
      OFF_LINK: begin
        rd_d[ASPM_LSB+:2] = aspm_q;
        rd_d[RCB_BIT] = 1'b0;
        rd_d[LDIS_BIT] = ldis_q;
        rd_d[RETR_BIT] = retr_q;
        rd_d[CCLK_BIT] = cclk_q;
        rd_d[XSYNC_BIT] = xsync_q;
        rd_d[SPEED_LSB+:4] = SPEED_RST;
        rd_d[WIDTH_LSB+:6] = width_q;
        rd_d[TERR_BIT] = terr_q;
        rd_d[TRAIN_BIT] = train_q;
        rd_d[SCLK_BIT] = 1'b1;
      end
      OFF_SLOT_CAP: begin
        rd_d[6:0] = hp_bits;
      end
      OFF_SLOT_CTL: begin
        rd_d[10:0] = slot_ctl_q;
      end
      OFF_STRAP: begin
        rd_d[0] = rev_q;
        rd_d[1] = hp_q;
        rd_d[2] = strap_cnt_q;
      end
      default: begin
        rd_d = 32'h0000_0000;
      end
    endcase
  end

  // Registered read data and control outputs.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_o <= 32'h0000_0000;
      aspm_ctl_o <= ASPM_RST;
      link_disable_o <= 1'b0;
      retrain_o <= 1'b0;
      slot_ctl_o <= SLOT_CTL_RST;
    end else begin
      dat_o <= (cyc_i && stb_i && !ack_o) ? rd_d : 32'h0000_0000;
      aspm_ctl_o <= aspm_q;
      link_disable_o <= ldis_q;
      retrain_o <= retr_q;
      slot_ctl_o <= slot_ctl_q;
    end
  end

  // Bus handshake: a one-cycle acknowledge that answers a request, data only while it stands.
  a_ack_one: assert property (@(posedge clk_i) disable iff (rst_i)
    ack_o |=> !ack_o) else $error("ack held two cycles");
  a_ack_req: assert property (@(posedge clk_i) disable iff (rst_i)
    ack_o |-> $past(cyc_i && stb_i)) else $error("ack without request");
  a_data_idle: assert property (@(posedge clk_i) disable iff (rst_i)
    !ack_o |-> dat_o == 32'h0000_0000) else $error("read data outside ack");

  // Register fields: reset values, read-only bits, write lanes and the strap-driven bits.
  a_aspm_reset: assert property (@(posedge clk_i)
    $fell(rst_i) |-> aspm_q == ASPM_RST) else $error("aspm not reset");
  a_rcb_zero: assert property (@(posedge clk_i) disable iff (rst_i)
    ack_o && $past(adr_i) == OFF_LINK |-> !dat_o[RCB_BIT]) else $error("rcb set");
  a_fwd_locked: assert property (@(posedge clk_i) disable iff (rst_i)
    !rev_q |=> $stable(ldis_q) && $stable(retr_q)) else $error("ro bit moved");
  a_rev_write: assert property (@(posedge clk_i) disable iff (rst_i)
    wr_go && rev_q && adr_i == OFF_LINK && sel_i[0] |=> ldis_q == $past(dat_i[LDIS_BIT])
      && retr_q == $past(dat_i[RETR_BIT])) else $error("link bits not written");
  a_slot_lane: assert property (@(posedge clk_i) disable iff (rst_i)
    wr_go && adr_i == OFF_SLOT_CTL && !sel_i[1] |=> $stable(slot_ctl_q[10:8])) else $error("lane");
  a_speed_one: assert property (@(posedge clk_i) disable iff (rst_i)
    ack_o && $past(adr_i) == OFF_LINK |-> dat_o[SPEED_LSB+:4] == SPEED_RST) else $error("speed");
  a_hp_caps: assert property (@(posedge clk_i) disable iff (rst_i)
    ack_o && $past(adr_i) == OFF_SLOT_CAP |-> dat_o[6:0] == ($past(hp_q && rev_q) ?
      HP_CAP_MASK : 7'h00)) else $error("bad slot caps");
  a_strap_load: assert property (@(posedge clk_i) disable iff (rst_i)
    hp_lvl |=> hp_q) else $error("strap not loaded");
  a_resv_zero: assert property (@(posedge clk_i) disable iff (rst_i)
    ack_o && $past(adr_i) == OFF_SLOT_CTL |-> dat_o[31:11] == 21'h00_0000) else $error("reserved");
  a_out_copy: assert property (@(posedge clk_i) disable iff (rst_i)
    1'b1 |=> aspm_ctl_o == $past(aspm_q) && slot_ctl_o == $past(slot_ctl_q))
    else $error("output copy stale");

  // Scenario coverage for both bridge directions, hot-plug and slot writes.
  c_rev_write: cover property (@(posedge clk_i) wr_go && rev_q && adr_i == OFF_LINK);
  c_fwd_write: cover property (@(posedge clk_i) wr_go && !rev_q && adr_i == OFF_LINK);
  c_hp_on: cover property (@(posedge clk_i) hp_q && rev_q);
  c_slot_wr: cover property (@(posedge clk_i) wr_go && adr_i == OFF_SLOT_CTL);
endmodule // link_slot_config_regs

// ---- testbench/tb.sv ----
// Self-checking bench for the link and slot configuration registers.
`timescale 1ns/10ps
module tb;
  import link_slot_pkg::*;
  logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, rev = 0, hp = 0, terr = 0, trn = 0;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'hF;
  logic [5:0] wid = 6'h04;
  logic [31:0] dat = 32'h0, rd, r, d;
  logic [7:0] c;
  logic ack, ldis, retr;
  logic [1:0] aspm;
  logic [10:0] sctl;
  integer failures = 0, compares = 0, seed = 41, i, p;
  // Clock of 50 ns period.
  always #25 clk_i = ~clk_i;
  link_slot_config_regs dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we),
    .adr_i(adr), .sel_i(sel), .dat_i(dat), .dat_o(rd), .ack_o(ack), .reverse_i(rev),
    .hotplug_strap_i(hp), .neg_width_i(wid), .train_err_i(terr), .training_i(trn),
    .aspm_ctl_o(aspm), .link_disable_o(ldis), .retrain_o(retr), .slot_ctl_o(sctl));
  // Compares a seen value with the expected one and counts a mismatch.
  task chk(input logic [31:0] s, input logic [31:0] e);
    compares++;
    if (s !== e) begin
      failures++;
      $display("CHECK FAILED %0t got %h expected %h", $time, s, e);
    end
  endtask
  // One classic Wishbone cycle; the request stands until ack is sampled high.
  task bus(input logic w, input logic [7:0] a, input logic [3:0] s, input logic [31:0] wd);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= s;
    dat <= wd;
    @(posedge clk_i);
    while (ack !== 1'b1) begin
      @(posedge clk_i);
    end
    r = rd;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    @(posedge clk_i);
  endtask
  // Expected link word from the control byte and the link state inputs.
  function logic [31:0] link_exp(input logic [7:0] ctl);
    return {3'h0, 1'b1, trn, terr, wid, SPEED_RST, 8'h00, ctl};
  endfunction
  // Expected hot-plug capability bits: set only for a hot-plug enabled reverse bridge.
  function logic [6:0] hp_exp(input logic rv, input logic hs);
    return (rv && hs) ? HP_CAP_MASK : 7'h00;
  endfunction
  // Prints the counts and the verdict, then ends the run.
  task give_verdict;
    $display("failures %0d compares %0d", failures, compares);
    if (failures == 0 && compares > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // Watchdog: a full run takes about 400 cycles, so 2000 cycles means a hung handshake.
  initial begin
    #100000;
    failures++;
    give_verdict;
  end
  // Main sequence over three strap settings, each entered through a reset.
  initial begin
    for (p = 0; p < 3; p++) begin
      rev <= (p != 0);
      hp <= (p != 2);
      rst_i <= 1'b1;
      wid <= 6'h04;
      terr <= 1'b0;
      trn <= 1'b0;
      repeat (16) @(posedge clk_i);
      rst_i <= 1'b0;
      repeat (8) @(posedge clk_i);
      chk({aspm, ldis, retr, sctl}, 32'h0000_0000);
      bus(1'b0, OFF_LINK, 4'hF, 32'h0000_0000);
      chk(r, link_exp(8'h00));
      bus(1'b0, OFF_STRAP, 4'hF, 32'h0000_0000);
      chk(r, {29'h0000_0000, 1'b1, hp, rev});
      bus(1'b0, OFF_SLOT_CAP, 4'hF, 32'h0000_0000);
      chk(r, {25'h000_0000, hp_exp(rev, hp)});
      d = r;
      bus(1'b1, OFF_SLOT_CAP, 4'hF, 32'hFFFF_FFFF);
      bus(1'b0, OFF_SLOT_CAP, 4'hF, 32'h0000_0000);
      chk(r, d);
      for (i = 0; i < 4; i++) begin
        d = $random(seed);
        d[1:0] = i[1:0];
        wid <= 6'h01 << (i + p);
        terr <= i[0];
        trn <= i[1];
        c = {d[7:6], rev ? d[5:4] : 2'b00, 2'b00, i[1:0]};
        bus(1'b1, OFF_LINK, 4'hF, d);
        chk({aspm, retr, ldis}, {28'h000_0000, c[1:0], c[5:4]});
        bus(1'b0, OFF_LINK, 4'hF, 32'h0000_0000);
        chk(r, link_exp(c));
        bus(1'b1, OFF_LINK, 4'h2, ~d);
        bus(1'b0, OFF_LINK, 4'hF, 32'h0000_0000);
        chk(r, link_exp(c));
        d = $random(seed);
        bus(1'b1, OFF_SLOT_CTL, 4'hF, d);
        chk(sctl, d[10:0]);
        bus(1'b1, OFF_SLOT_CTL, 4'h1, ~d);
        chk(sctl, {d[10:8], ~d[7:0]});
        bus(1'b0, OFF_SLOT_CTL, 4'hF, 32'h0000_0000);
        chk(r, {21'h00_0000, d[10:8], ~d[7:0]});
      end
      bus(1'b0, 8'h10, 4'hF, 32'h0000_0000);
      chk(r, 32'h0000_0000);
    end
    give_verdict;
  end
endmodule // tb
